/* File: common/spl_pkg.sv */
// constants and behaviour summary for the serial pll configuration loader
// Behaviour
// - unloaded device drives reference on all nine outputs
// - 160 bits shifted in, most significant first
// - strobe rise copies shift register; lock within 10 ms
// - latch transparent while strobe high, shifts propagate
// - power-down low tri-states every clock output
// - load under power-down, outputs appear on release
// - reload while running, relock within 10 ms
// - multiplier 1..2048, reference divider 1..1024 settable
// - bank clock = ref * mult / div / outdiv
package spl_pkg;
  // -----------------------------------------------------------------
  // geometry
  // -----------------------------------------------------------------
  localparam int CFG_BITS = 160;
  localparam int NUM_CLK = 9;
  localparam int BANK0_CLKS = 5;
  // -----------------------------------------------------------------
  // input synchroniser slots
  // -----------------------------------------------------------------
  localparam int IN_DATA = 0;
  localparam int IN_SCLK = 1;
  localparam int IN_STROBE = 2;
  localparam int IN_PDN = 3;
  localparam int IN_REF = 4;
  localparam int NUM_IN = 5;
  localparam logic [4:0] SYNC_RST = 5'h0C;
  // -----------------------------------------------------------------
  // configuration word fields
  // -----------------------------------------------------------------
  localparam int MULT_LSB = 0;
  localparam int MULT_W = 11;
  localparam int RDIV_LSB = 11;
  localparam int RDIV_W = 10;
  localparam int ODIV0_LSB = 21;
  localparam int ODIV1_LSB = 26;
  localparam int ODIV_W = 5;
  localparam int SYNTH_EN_BIT = 31;
  localparam logic [4:0] ODIV_MIN = 5'h02;
  localparam logic [4:0] ODIV_MAX = 5'h14;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CORE_CLK_HZ = 100000000;
  localparam int LOCK_TIME_MS = 10;
  localparam int LOCK_CYCLES = LOCK_TIME_MS * (CORE_CLK_HZ / 1000);
  localparam int LOCK_CNT_W = 20;
  localparam int ACC_W = 16;
endpackage

/* File: src/spl_cfg_store.sv */
// shift register and configuration latch
`timescale 1ns/1ns
`default_nettype none
module spl_cfg_store
  import spl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // control from the core
  input wire logic shiftEn,
  input wire logic bitIn,
  input wire logic loadEn,
  input wire logic transparent,
  // stored word
  output logic [CFG_BITS-1:0] cfgWord,
  output logic loaded
);
  typedef struct packed {
    logic [CFG_BITS-1:0] sh;
    logic [CFG_BITS-1:0] cfg;
    logic loaded;
  } spl_store_t;

  spl_store_t st_q;
  spl_store_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (shiftEn)
    begin
      st_d.sh = {st_q.sh[CFG_BITS-2:0], bitIn};
    end
    // a shift while strobe is high reaches the latch at once
    if (loadEn || (transparent && shiftEn))
    begin
      st_d.cfg = st_d.sh;
      st_d.loaded = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign cfgWord = st_q.cfg;
  assign loaded = st_q.loaded;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_shift_msb;
    @(posedge core_clk) disable iff (!rst_b)
    shiftEn |=> st_q.sh == {$past(st_q.sh[CFG_BITS-2:0]), $past(bitIn)};
  endproperty
  a_shift_msb: assert property (p_shift_msb) else $error("shift order wrong");

  property p_strobe_load;
    @(posedge core_clk) disable iff (!rst_b)
    (loadEn && !shiftEn) |=> (st_q.cfg == $past(st_q.sh)) && st_q.loaded;
  endproperty
  a_strobe_load: assert property (p_strobe_load) else $error("load missed");

  property p_transparent;
    @(posedge core_clk) disable iff (!rst_b)
    (transparent && shiftEn) |=> st_q.cfg == st_q.sh;
  endproperty
  a_transparent: assert property (p_transparent) else $error("latch not transparent");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_b)
    !loadEn && !transparent |=> $stable(st_q.cfg);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed while closed");
endmodule // spl_cfg_store
`default_nettype wire

/* File: src/spl_loader.sv */
// serial pll configuration loader: pin sampling, lock timing, output control
`timescale 1ns/1ns
`default_nettype none
module spl_loader
  import spl_pkg::*;
#(
  parameter int unsigned LOCK_CYC = LOCK_CYCLES
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // programming pins
  input wire logic serialData,
  input wire logic serialClk,
  input wire logic loadStrobe,
  input wire logic powerDownTristate_n,
  // reference clock
  input wire logic refClk,
  // clock outputs, index 0 is clock_output_one, index 8 clock_output_nine
  output logic [NUM_CLK-1:0] clockOutput,
  output logic [NUM_CLK-1:0] clockOutputOe,
  // status
  output logic locked
);
  typedef struct packed {
    logic [NUM_IN-1:0] s1;
    logic [NUM_IN-1:0] s2;
    logic [NUM_IN-1:0] s3;
    logic [NUM_IN-1:0] f;
    logic [LOCK_CNT_W-1:0] lockCnt;
    logic locked;
    logic [ACC_W-1:0] acc0;
    logic [ACC_W-1:0] acc1;
    logic ph0;
    logic ph1;
    logic [NUM_CLK-1:0] clkOut;
    logic [NUM_CLK-1:0] clkOe;
  } spl_core_t;

  localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_CYC - 1);

  spl_core_t st_q;
  spl_core_t st_d;
  logic [CFG_BITS-1:0] cfgWord;
  logic cfgLoaded;
  logic [NUM_IN-1:0] settled;
  logic [NUM_IN-1:0] rise;
  logic cfgUpd;
  logic useSynth;
  logic [ACC_W-1:0] step;
  logic [ACC_W-1:0] half0;
  logic [ACC_W-1:0] half1;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // out-of-range output divider codes are clamped rather than trusted
  function automatic logic [4:0] odivOf(input logic [4:0] code);
    if (code < ODIV_MIN)
      return ODIV_MIN;
    else if (code > ODIV_MAX)
      return ODIV_MAX;
    else
      return code;
  endfunction

  // toggle threshold: reference divider times output divider
  function automatic logic [ACC_W-1:0] periodOf(input logic [RDIV_W-1:0] rdivM1,
                                                input logic [4:0] odiv);
    logic [ACC_W-1:0] n;
    n = ACC_W'({1'b0, rdivM1}) + 16'h0001;
    return ACC_W'(n * ACC_W'(odivOf(odiv)));
  endfunction

  // one accumulator step: advance, toggle when a half period is crossed
  function automatic logic [ACC_W:0] accStep(input logic [ACC_W-1:0] acc,
                                             input logic [ACC_W-1:0] add,
                                             input logic [ACC_W-1:0] half);
    logic [ACC_W-1:0] sum;
    sum = acc + add;
    if (sum >= half)
      return {1'b1, ACC_W'(sum - half)};
    else
      return {1'b0, sum};
  endfunction

  // -----------------------------------------------------------------
  // configuration store
  // -----------------------------------------------------------------
  spl_cfg_store u_store (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .shiftEn(rise[IN_SCLK]),
    .bitIn(st_q.f[IN_DATA]),
    .loadEn(rise[IN_STROBE]),
    .transparent(st_q.f[IN_STROBE]),
    .cfgWord(cfgWord),
    .loaded(cfgLoaded)
  );

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    settled = ~(st_q.s2 ^ st_q.s3);
    rise = settled & st_q.s2 & ~st_q.f;
    cfgUpd = rise[IN_STROBE] || (st_q.f[IN_STROBE] && rise[IN_SCLK]);
    useSynth = cfgLoaded && cfgWord[SYNTH_EN_BIT];
    // doubled step on each reference rise so one output period spans two toggles
    step = rise[IN_REF] ? ACC_W'({cfgWord[MULT_LSB +: MULT_W], 1'b0}) + 16'h0002 : 16'h0000;
    half0 = periodOf(cfgWord[RDIV_LSB +: RDIV_W], cfgWord[ODIV0_LSB +: ODIV_W]);
    half1 = periodOf(cfgWord[RDIV_LSB +: RDIV_W], cfgWord[ODIV1_LSB +: ODIV_W]);
    st_d = st_q;
    st_d.s1 = {refClk, powerDownTristate_n, loadStrobe, serialClk, serialData};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.f = (settled & st_q.s2) | (~settled & st_q.f);
    // relock after every latch update, also while outputs are running
    if (cfgUpd)
    begin
      st_d.lockCnt = '0;
      st_d.locked = 1'b0;
      st_d.acc0 = '0;
      st_d.acc1 = '0;
      st_d.ph0 = 1'b0;
      st_d.ph1 = 1'b0;
    end
    else
    begin
      // counter parks at its last value so it never runs past the bound
      if (!st_q.locked)
      begin
        if (st_q.lockCnt == LOCK_LAST)
          st_d.locked = 1'b1;
        else
          st_d.lockCnt = st_q.lockCnt + 20'h00001;
      end
      {st_d.ph0, st_d.acc0} = accStep(st_q.acc0, step, half0) ^ {st_q.ph0, {ACC_W{1'b0}}};
      {st_d.ph1, st_d.acc1} = accStep(st_q.acc1, step, half1) ^ {st_q.ph1, {ACC_W{1'b0}}};
    end
    if (!st_q.f[IN_PDN])
    begin
      st_d.clkOe = '0;
      st_d.clkOut = '0;
    end
    else
    begin
      st_d.clkOe = '1;
      if (!useSynth)
        st_d.clkOut = {NUM_CLK{st_q.f[IN_REF]}};
      else if (!st_q.locked)
        st_d.clkOut = '0;
      else
        st_d.clkOut = {{(NUM_CLK-BANK0_CLKS){st_q.ph1}}, {BANK0_CLKS{st_q.ph0}}};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.s1 <= SYNC_RST;
      st_q.s2 <= SYNC_RST;
      st_q.s3 <= SYNC_RST;
      st_q.f <= SYNC_RST;
    end
    else
      st_q <= st_d;
  end

  assign clockOutput = st_q.clkOut;
  assign clockOutputOe = st_q.clkOe;
  assign locked = st_q.locked;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_ref_pass;
    @(posedge core_clk) disable iff (!rst_b)
    (st_q.f[IN_PDN] && !useSynth) |=> clockOutput == {NUM_CLK{$past(st_q.f[IN_REF])}};
  endproperty
  a_ref_pass: assert property (p_ref_pass) else $error("reference not passed");

  property p_sample_rise;
    @(posedge core_clk) disable iff (!rst_b)
    $rose(st_q.f[IN_SCLK]) |-> $past(rise[IN_SCLK]);
  endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("shift edge missed");

  property p_tristate;
    @(posedge core_clk) disable iff (!rst_b)
    !st_q.f[IN_PDN] |=> (clockOutputOe == '0) && (clockOutput == '0);
  endproperty
  a_tristate: assert property (p_tristate) else $error("outputs driven in power-down");

  property p_release;
    @(posedge core_clk) disable iff (!rst_b)
    $rose(st_q.f[IN_PDN]) |=> clockOutputOe == '1;
  endproperty
  a_release: assert property (p_release) else $error("outputs not enabled");

  property p_relock_start;
    @(posedge core_clk) disable iff (!rst_b)
    cfgUpd |=> !locked && (st_q.lockCnt == '0);
  endproperty
  a_relock_start: assert property (p_relock_start) else $error("relock not restarted");

  property p_lock_bound;
    @(posedge core_clk) disable iff (!rst_b)
    st_q.lockCnt <= LOCK_LAST;
  endproperty
  a_lock_bound: assert property (p_lock_bound) else $error("lock time exceeded");

  property p_hold_low;
    @(posedge core_clk) disable iff (!rst_b)
    (st_q.f[IN_PDN] && useSynth && !locked) |=> clockOutput == '0;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("output ran before lock");

  property p_odiv_range;
    @(posedge core_clk) disable iff (!rst_b)
    (odivOf(cfgWord[ODIV0_LSB +: ODIV_W]) >= ODIV_MIN)
      && (odivOf(cfgWord[ODIV1_LSB +: ODIV_W]) <= ODIV_MAX);
  endproperty
  a_odiv_range: assert property (p_odiv_range) else $error("output divider range");

  property p_half_range;
    @(posedge core_clk) disable iff (!rst_b)
    (half0 >= 16'h0002) && (half1 <= 16'h5000);
  endproperty
  a_half_range: assert property (p_half_range) else $error("divider product range");

  c_load: cover property (@(posedge core_clk) disable iff (!rst_b) rise[IN_STROBE]);
  c_transparent: cover property (@(posedge core_clk) disable iff (!rst_b)
    st_q.f[IN_STROBE] && rise[IN_SCLK]);
  c_locked: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(locked));
  c_powerdown: cover property (@(posedge core_clk) disable iff (!rst_b)
    $fell(st_q.f[IN_PDN]));
endmodule // spl_loader
`default_nettype wire

/* File: verification/spl_host_model.sv */
// host model driving the three-wire programming pins
`timescale 1ns/1ns
`default_nettype none
module spl_host_model
  import spl_pkg::*;
(
  // bench request
  input wire logic core_clk,
  input wire logic req,
  input wire logic [CFG_BITS-1:0] word,
  input wire logic holdHigh,
  // programming pins
  output logic serialData,
  output logic serialClk,
  output logic loadStrobe,
  output logic done
);
  // ----------------------------------------
  // one frame: 160 shifts at 80 ns, then strobe
  // ----------------------------------------
  initial
  begin
    serialData = 1'h0;
    serialClk = 1'h0;
    loadStrobe = 1'h0;
    done = 1'h0;
    forever
    begin
      @(posedge core_clk);
      if (req)
      begin
        done <= 1'h0;
        loadStrobe <= holdHigh;
        for (int i = CFG_BITS - 1; i >= 0; i--)
        begin
          serialData <= word[i];
          #40 serialClk <= 1'h1;
          #40 serialClk <= 1'h0;
        end
        // no stale level once the hold time is over
        serialData <= ~word[0];
        #40 loadStrobe <= 1'h1;
        #80 loadStrobe <= 1'h0;
        @(posedge core_clk);
        done <= 1'h1;
      end
    end
  end
endmodule // spl_host_model
`default_nettype wire

/* File: verification/tb_serial_pll_config_loader.sv */
// self-checking bench for the serial pll configuration loader
`timescale 1ns/1ns
`default_nettype none
module tb_serial_pll_config_loader
  import spl_pkg::*;
#(
  parameter int unsigned LOCK = 50
);
  logic core_clk;
  logic rst_b;
  logic refClk;
  logic pdn;
  logic req;
  logic holdHigh;
  logic serialData;
  logic serialClk;
  logic loadStrobe;
  logic done;
  logic locked;
  logic [NUM_CLK-1:0] clockOutput;
  logic [NUM_CLK-1:0] clockOutputOe;
  logic [CFG_BITS-1:0] word;
  logic [31:0] lfsr;
  int failures = 0;
  int testsRun = 0;
  int cycles = 0;
  int m;
  int n;
  int o0;
  int o1;

  spl_loader #(.LOCK_CYC(LOCK)) dut_u (.core_clk(core_clk), .rst_b(rst_b),
    .serialData(serialData), .serialClk(serialClk), .loadStrobe(loadStrobe),
    .powerDownTristate_n(pdn), .refClk(refClk), .clockOutput(clockOutput),
    .clockOutputOe(clockOutputOe), .locked(locked));
  spl_host_model host_u (.core_clk(core_clk), .req(req), .word(word), .holdHigh(holdHigh),
    .serialData(serialData), .serialClk(serialClk), .loadStrobe(loadStrobe), .done(done));

  // ----------------------------------------
  // clocks, helpers
  // ----------------------------------------
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  // 200 ns reference: slow enough that core sampling sees every phase
  initial
  begin
    refClk = 1'h0;
    #2;
    forever #100 refClk = ~refClk;
  end

  function automatic int draw(input int range);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return int'(lfsr[15:0]) % range;
  endfunction

  function automatic logic [CFG_BITS-1:0] makeWord(input int mm, input int nn, input int d0,
    input int d1);
    logic [CFG_BITS-1:0] w;
    w = {5{lfsr}};
    w[MULT_LSB +: MULT_W] = MULT_W'(mm - 1);
    w[RDIV_LSB +: RDIV_W] = RDIV_W'(nn - 1);
    w[ODIV0_LSB +: ODIV_W] = ODIV_W'(d0);
    w[ODIV1_LSB +: ODIV_W] = ODIV_W'(d1);
    w[SYNTH_EN_BIT] = 1'h1;
    return w;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("failures %0d checks %0d", failures, testsRun);
    if (failures == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // load and measure
  // ----------------------------------------
  task automatic shiftIn(input int mm, input int nn, input int d0, input int d1, input logic h);
    int k;
    word <= makeWord(mm, nn, d0, d1);
    holdHigh <= h;
    req <= 1'h1;
    @(posedge core_clk);
    req <= 1'h0;
    // done of the previous frame is still high until the host drops it
    @(posedge core_clk);
    k = 0;
    while (done !== 1'h1 && k < 3000)
    begin
      @(posedge core_clk);
      k++;
    end
    check(32'(locked), 32'h0);
    check(32'(clockOutput), 32'h0);
    k = 0;
    while (locked !== 1'h1 && k < 2 * LOCK)
    begin
      @(posedge core_clk);
      k++;
    end
    check(32'(k >= LOCK - 24 && k < LOCK), 32'h1);
  endtask

  // phase offset and accumulator jitter allow one rise either way
  task automatic freqCheck(input int mm, input int nn, input int d0, input int d1);
    int r0;
    int r1;
    int e0;
    int e1;
    int bad;
    logic [NUM_CLK-1:0] prev;
    r0 = 0;
    r1 = 0;
    bad = 0;
    e0 = 80 * mm / (nn * d0);
    e1 = 80 * mm / (nn * d1);
    prev = clockOutput;
    repeat (1600)
    begin
      @(posedge core_clk);
      r0 += int'(clockOutput[0] & ~prev[0]);
      r1 += int'(clockOutput[5] & ~prev[5]);
      bad += int'(clockOutput[4:0] != {5{clockOutput[0]}});
      bad += int'(clockOutput[8:5] != {4{clockOutput[5]}});
      prev = clockOutput;
    end
    check(32'(r0 <= e0 + 1 && r0 + 1 >= e0), 32'h1);
    check(32'(r1 <= e1 + 1 && r1 + 1 >= e1), 32'h1);
    check(32'(bad), 32'h0);
    check(32'(clockOutputOe), 32'h1FF);
  endtask

  task automatic loadAndCheck(input int mm, input int nn, input int d0, input int d1,
    input logic h);
    shiftIn(mm, nn, d0, d1, h);
    freqCheck(mm, nn, d0, d1);
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      failures++;
      $display("CHECK FAILED %0t timeout", $time);
      stop_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_b = 1'h0;
    pdn = 1'h1;
    req = 1'h0;
    holdHigh = 1'h0;
    word = {CFG_BITS{1'h0}};
    lfsr = 32'h00011308;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (20) @(posedge core_clk);
    repeat (3)
    begin
      @(posedge refClk);
      repeat (7) @(posedge core_clk);
      check(32'(clockOutput), 32'h1FF);
      @(negedge refClk);
      repeat (7) @(posedge core_clk);
      check(32'(clockOutput), 32'h0);
    end
    pdn <= 1'h0;
    repeat (6) @(posedge core_clk);
    check(32'(clockOutputOe), 32'h0);
    check(32'(clockOutput), 32'h0);
    pdn <= 1'h1;
    repeat (6) @(posedge core_clk);
    check(32'(clockOutputOe), 32'h1FF);
    pdn <= 1'h0;
    shiftIn(3, 2, 6, 10, 1'h0);
    check(32'(clockOutputOe), 32'h0);
    pdn <= 1'h1;
    repeat (8) @(posedge core_clk);
    freqCheck(3, 2, 6, 10);
    loadAndCheck(2048, 1024, 4, 20, 1'h0);
    loadAndCheck(1, 1, 2, 20, 1'h0);
    repeat (4)
    begin
      n = 1 + draw(4);
      o0 = 2 + draw(19);
      o1 = 2 + draw(19);
      m = 1 + draw(n * (o0 < o1 ? o0 : o1) / 2);
      loadAndCheck(m, n, o0, o1, 1'h0);
    end
    loadAndCheck(3, 2, 4, 8, 1'h1);
    stop_test();
  end
endmodule // tb_serial_pll_config_loader
`default_nettype wire
